/* File: hdl/smisc_pkg.sv */
// package of constants and types for the sideband service-mode and clock-halt controller
// Contract
// - asserted service interrupt input makes the device enter protected service mode; the code ignores it while halted and while out_float is high
// - entering protected service mode issues one acknowledge transaction on the bus
// - after that acknowledge the core starts fetching from the service handler
// - service interrupt held during reset release floats every output of the device; the code raises out_float and masks only bus_ack_valid
// - while clock halt request is asserted the device enters the clock-halted state; the code does not halt in service mode or while out_float is high
// - entering the clock-halted state issues a halt acknowledge transaction on the bus
// - when halted, core clocks are gated; bus unit and interrupt controller keep running
// - when halted, bus snooping and interrupt servicing carry on
// - releasing the halt request re-enables all clocks and resumes execution
// - the bus clock is never gated by a halt request
// - the halt request is asynchronous and is synchronised inside the device
package smisc_pkg;
  // acknowledge transaction codes
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_SVC  = 2'h1;
  localparam logic [1:0] ACK_HALT = 2'h2;
  // reset values
  localparam logic       RST_FLOAT = 1'b0;
  localparam logic       RST_GATE  = 1'b0;
  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    SMISC_RESET,
    SMISC_RUN,
    SMISC_SVC_ACK,
    SMISC_SVC,
    SMISC_HALT_ACK,
    SMISC_HALT
  } smisc_state_t;
endpackage

/* File: hdl/smisc_ack_if.sv */
// interface carrying acknowledge transaction requests to the bus issue stage
`timescale 1ns/1ps
`default_nettype none
interface smisc_ack_if;
  logic       req;
  logic [1:0] code;
  logic       done;
  modport ctrl (output req, output code, input done);
  modport bus  (input req, input code, output done);
endinterface
`default_nettype wire

/* File: hdl/smisc_ack_issue.sv */
// bus issue stage: drives one acknowledge transaction per request
`timescale 1ns/1ps
`default_nettype none
module smisc_ack_issue (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // request side
  smisc_ack_if.bus   ack,
  // bus side
  output logic       bus_ack_valid,
  output logic [1:0] bus_ack_code,
  input  wire logic  bus_ack_ready
);
  typedef struct packed {
    logic       valid;
    logic [1:0] code;
    logic       done;
  } smisc_iss_t;

  smisc_iss_t s_q;
  smisc_iss_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (s_q.valid) begin
      if (bus_ack_ready) begin
        s_d.valid = 1'b0;
        s_d.done  = 1'b1;
        s_d.code  = smisc_pkg::ACK_NONE;
      end
    end else if (ack.req && !s_q.done) begin
      s_d.valid = 1'b1;
      s_d.code  = ack.code;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_ack_valid = s_q.valid;
  assign bus_ack_code  = s_q.code;
  assign ack.done      = s_q.done;
endmodule
`default_nettype wire

/* File: hdl/smisc_ctrl.sv */
// sideband controller for protected service entry and clock halting
`timescale 1ns/1ps
`default_nettype none
module smisc_ctrl (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // sideband pins
  input  wire logic  sys_mgmt_irq_n,
  input  wire logic  clock_halt_req_n,
  // core handshake
  input  wire logic  svc_exit,
  // acknowledge transaction bus
  output logic       bus_ack_valid,
  output logic [1:0] bus_ack_code,
  input  wire logic  bus_ack_ready,
  // core status and clock gating
  output logic       protected_service_mode,
  output logic       svc_fetch_start,
  output logic       core_clk_en,
  output logic       bus_unit_clk_en,
  output logic       local_interrupt_controller_clk_en,
  output logic       snoop_en,
  output logic       irq_service_en,
  output logic       out_float
);
  typedef struct packed {
    logic [1:0]                 smi_sync;
    logic [1:0]                 halt_sync;
    smisc_pkg::smisc_state_t    st;
    logic                       req;
    logic [1:0]                 code;
    logic                       svc;
    logic                       fetch;
    logic                       gate;
    logic                       flt;
    logic                       rst_seen;
  } smisc_ctrl_t;

  smisc_ctrl_t s_q;
  smisc_ctrl_t s_d;
  logic        smi_act;
  logic        halt_act;
  logic        bus_vld;
  logic [1:0]  bus_code;

  smisc_ack_if ack_if ();

  smisc_ack_issue u_issue (
    .clk           (clk),
    .rst           (rst),
    .ack           (ack_if.bus),
    .bus_ack_valid (bus_vld),
    .bus_ack_code  (bus_code),
    .bus_ack_ready (bus_ack_ready)
  );

  assign ack_if.req  = s_q.req;
  assign ack_if.code = s_q.code;
  assign smi_act     = ~s_q.smi_sync[1];
  assign halt_act    = ~s_q.halt_sync[1];

  always_comb begin
    s_d           = s_q;
    s_d.smi_sync  = {s_q.smi_sync[0], sys_mgmt_irq_n};
    s_d.halt_sync = {s_q.halt_sync[0], clock_halt_req_n};
    s_d.fetch     = 1'b0;
    case (s_q.st)
      smisc_pkg::SMISC_RESET: begin
        // sample service input at release of reset
        s_d.flt      = smi_act;
        s_d.rst_seen = 1'b1;
        if (s_q.rst_seen) begin
          s_d.st = smisc_pkg::SMISC_RUN;
        end
      end
      smisc_pkg::SMISC_RUN: begin
        if (s_q.flt) begin
          s_d.st = smisc_pkg::SMISC_RUN;
        end else if (smi_act) begin
          s_d.st   = smisc_pkg::SMISC_SVC_ACK;
          s_d.svc  = 1'b1;
          s_d.req  = 1'b1;
          s_d.code = smisc_pkg::ACK_SVC;
        end else if (halt_act) begin
          s_d.st   = smisc_pkg::SMISC_HALT_ACK;
          s_d.req  = 1'b1;
          s_d.code = smisc_pkg::ACK_HALT;
        end
      end
      smisc_pkg::SMISC_SVC_ACK: begin
        if (ack_if.done) begin
          s_d.req   = 1'b0;
          s_d.code  = smisc_pkg::ACK_NONE;
          s_d.fetch = 1'b1;
          s_d.st    = smisc_pkg::SMISC_SVC;
        end
      end
      smisc_pkg::SMISC_SVC: begin
        if (svc_exit) begin
          s_d.svc = 1'b0;
          s_d.st  = smisc_pkg::SMISC_RUN;
        end
      end
      smisc_pkg::SMISC_HALT_ACK: begin
        if (ack_if.done) begin
          s_d.req  = 1'b0;
          s_d.code = smisc_pkg::ACK_NONE;
          s_d.gate = 1'b1;
          s_d.st   = smisc_pkg::SMISC_HALT;
        end
      end
      smisc_pkg::SMISC_HALT: begin
        if (!halt_act) begin
          s_d.gate = 1'b0;
          s_d.st   = smisc_pkg::SMISC_RUN;
        end
      end
      default: begin
        s_d.st = smisc_pkg::SMISC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q           <= '0;
      // keep sampling the service pin so its level at release is known
      s_q.smi_sync  <= {s_q.smi_sync[0], sys_mgmt_irq_n};
      s_q.halt_sync <= 2'h3;
      s_q.st        <= smisc_pkg::SMISC_RESET;
      s_q.gate      <= smisc_pkg::RST_GATE;
      s_q.flt       <= smisc_pkg::RST_FLOAT;
    end else begin
      s_q <= s_d;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_ack_valid                     <= 1'b0;
      bus_ack_code                      <= smisc_pkg::ACK_NONE;
      protected_service_mode            <= 1'b0;
      svc_fetch_start                   <= 1'b0;
      core_clk_en                       <= 1'b1;
      bus_unit_clk_en                   <= 1'b1;
      local_interrupt_controller_clk_en <= 1'b1;
      snoop_en                          <= 1'b1;
      irq_service_en                    <= 1'b1;
      out_float                         <= 1'b0;
    end else begin
      bus_ack_valid                     <= bus_vld & ~s_q.flt;
      bus_ack_code                      <= bus_code;
      protected_service_mode            <= s_q.svc;
      svc_fetch_start                   <= s_q.fetch;
      core_clk_en                       <= ~s_q.gate;
      bus_unit_clk_en                   <= 1'b1;
      local_interrupt_controller_clk_en <= 1'b1;
      snoop_en                          <= 1'b1;
      irq_service_en                    <= 1'b1;
      out_float                         <= s_q.flt;
    end
  end
endmodule
`default_nettype wire

/* File: test/smisc_ctrl_props.sv */
// checker of the service and halt controller ports
`timescale 1ns/1ps
`default_nettype none
module smisc_ctrl_props (
  input wire logic       clk, rst, sys_mgmt_irq_n, clock_halt_req_n,
  input wire logic       bus_ack_valid, bus_ack_ready, protected_service_mode,
  input wire logic [1:0] bus_ack_code,
  input wire logic       svc_fetch_start, core_clk_en, bus_unit_clk_en, snoop_en,
  input wire logic       irq_service_en, out_float
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence acc(logic [1:0] c);
    bus_ack_valid && bus_ack_ready && bus_ack_code == c;
  endsequence
  sequence run_idle;
    sys_mgmt_irq_n && !out_float && core_clk_en && !protected_service_mode && !bus_ack_valid;
  endsequence
  a_svc_enter: assert property (acc(2'h1) |-> ##[1:6] protected_service_mode)
    else $error("no service mode");
  a_svc_fetch: assert property (acc(2'h1) |-> ##[1:8] svc_fetch_start)
    else $error("no fetch start");
  a_float_on: assert property ($fell(rst) && !sys_mgmt_irq_n |-> ##[1:5] out_float)
    else $error("no float");
  a_float_quiet: assert property (out_float |-> !bus_ack_valid && core_clk_en)
    else $error("active while floating");
  a_halt_entry: assert property ($fell(clock_halt_req_n) ##0 run_idle |->
    ##[3:8] bus_ack_valid && bus_ack_code == 2'h2) else $error("no halt ack");
  a_halt_units: assert property (!core_clk_en |-> bus_unit_clk_en && snoop_en
    && irq_service_en) else $error("unit stopped");
  a_halt_resume: assert property ($rose(clock_halt_req_n) && !core_clk_en |->
    ##[2:8] core_clk_en) else $error("no resume");
  a_one_ack: assert property ($fell(bus_ack_valid) |-> !bus_ack_valid [*3])
    else $error("second ack");
endmodule
bind smisc_ctrl smisc_ctrl_props i_smisc_ctrl_props (.clk, .rst, .sys_mgmt_irq_n,
  .clock_halt_req_n, .bus_ack_valid, .bus_ack_ready, .bus_ack_code, .protected_service_mode,
  .svc_fetch_start, .core_clk_en, .bus_unit_clk_en, .snoop_en, .irq_service_en, .out_float);
`default_nettype wire

/* File: test/smisc_bus_partner.sv */
// chipset side acceptor of acknowledge transactions
`timescale 1ns/1ps
`default_nettype none
module smisc_bus_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       bus_ack_valid,
  input  wire logic [3:0] stall,
  output logic            bus_ack_ready
);
  logic [3:0] wait_q;
  always @(posedge clk) begin
    if (rst || !bus_ack_valid) begin
      wait_q <= 4'h0;
      bus_ack_ready <= 1'b0;
    end else begin
      wait_q <= wait_q + 4'h1;
      bus_ack_ready <= (wait_q == stall);
    end
  end
endmodule
`default_nettype wire

/* File: test/smisc_ctrl_tb.sv */
// testbench of the service and halt controller
`timescale 1ns/1ps
`default_nettype none
module smisc_ctrl_tb;
  logic clk = 0, rst = 1, sys_mgmt_irq_n = 1, clock_halt_req_n = 1, svc_exit = 0;
  logic [1:0] bus_ack_code;
  logic bus_ack_valid, bus_ack_ready, protected_service_mode, svc_fetch_start, core_clk_en;
  logic bus_unit_clk_en, local_interrupt_controller_clk_en, snoop_en, irq_service_en, out_float;
  logic [3:0] stall = 0;
  int bad_count = 0, num_checks = 0, n_svc = 0, n_halt = 0, n_fetch = 0;
  always #10 clk = ~clk;
  smisc_ctrl i_smisc_ctrl (.clk, .rst, .sys_mgmt_irq_n, .clock_halt_req_n, .svc_exit,
    .bus_ack_valid, .bus_ack_code, .bus_ack_ready, .protected_service_mode, .svc_fetch_start,
    .core_clk_en, .bus_unit_clk_en, .local_interrupt_controller_clk_en, .snoop_en,
    .irq_service_en, .out_float);
  smisc_bus_partner i_smisc_bus_partner (.clk, .rst, .bus_ack_valid, .stall, .bus_ack_ready);
  always @(posedge clk) begin
    n_svc <= n_svc + int'(bus_ack_valid && bus_ack_ready && bus_ack_code === 2'h1);
    n_halt <= n_halt + int'(bus_ack_valid && bus_ack_ready && bus_ack_code === 2'h2);
    n_fetch <= n_fetch + int'(svc_fetch_start === 1'b1);
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic await(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) @(negedge clk);
  endtask
  task automatic do_reset(logic irq);
    @(negedge clk);
    rst = 1;
    sys_mgmt_irq_n = irq;
    repeat (20) @(negedge clk);
    rst = 0;
    repeat (8) @(negedge clk);
  endtask
  task automatic t_float;
    do_reset(0);
    chk("out_float", 1, out_float);
    sys_mgmt_irq_n = 1;
    clock_halt_req_n = 0;
    repeat (12) @(negedge clk);
    chk("halt acks", 0, 8'(n_halt));
    chk("core_clk_en", 1, core_clk_en);
    clock_halt_req_n = 1;
    do_reset(1);
    chk("out_float", 0, out_float);
    $display("test float done");
  endtask
  task automatic t_halt(logic [3:0] s);
    int h;
    h = n_halt;
    stall = s;
    clock_halt_req_n = 0;
    await(core_clk_en, 0);
    chk("core_clk_en", 0, core_clk_en);
    chk("halt acks", 8'(h + 1), 8'(n_halt));
    chk("units", 4'hf, {bus_unit_clk_en, local_interrupt_controller_clk_en,
      snoop_en, irq_service_en});
    repeat (10) @(negedge clk);
    chk("halt acks", 8'(h + 1), 8'(n_halt));
    clock_halt_req_n = 1;
    await(core_clk_en, 1);
    chk("core_clk_en", 1, core_clk_en);
    repeat (4) @(negedge clk);
    $display("test halt done");
  endtask
  task automatic t_svc;
    sys_mgmt_irq_n = 0;
    await(protected_service_mode, 1);
    chk("mode", 1, protected_service_mode);
    clock_halt_req_n = 0;
    sys_mgmt_irq_n = 1;
    repeat (16) @(negedge clk);
    chk("svc acks", 1, 8'(n_svc));
    chk("fetch", 1, 8'(n_fetch));
    chk("core_clk_en", 1, core_clk_en);
    clock_halt_req_n = 1;
    repeat (4) @(negedge clk);
    svc_exit = 1;
    @(negedge clk);
    svc_exit = 0;
    await(protected_service_mode, 0);
    chk("mode", 0, protected_service_mode);
    repeat (8) @(negedge clk);
    chk("halt acks", 2, 8'(n_halt));
    $display("test service done");
  endtask
  initial begin
    t_float;
    t_halt(0);
    t_halt(5);
    t_svc;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
